// ### core/qdr_pkg.sv
// qdr_pkg: constants, register map and state codes of the converter readback slave.
// assumes: shared by the top module, the bound assertions and the testbench.
package qdr_pkg;

  // apb data path and register map (byte addresses, one aligned word each)
  localparam int          APB_DW       = 32;
  localparam int          APB_AW_MIN   = 8;
  localparam logic [7:0]  OFS_PIN_ADDR = 8'h00;
  localparam logic [7:0]  OFS_PWR_MODE = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_CH_BASE  = 8'h10;

  // channel data words
  localparam int          NUM_CH       = 4;
  localparam int          DATA_W       = 10;
  localparam logic [9:0]  CH_RST       = 10'h000;

  // reset values of the software registers and the control byte
  localparam logic [1:0]  PIN_ADDR_RST = 2'h0;
  localparam logic [1:0]  PWR_MODE_RST = 2'h0;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  // bus address: fixed upper five bits, pin_address_bit_1/0 below them
  localparam logic [4:0]  SLAVE_BASE   = 5'h13;

  // control byte field positions
  localparam int          CTL_PD_BIT   = 0;
  localparam int          CTL_CH_LSB   = 1;
  localparam int          CTL_UPD_LSB  = 4;
  localparam int          CTL_EXT_LSB  = 6;

  // power-down status byte filler and power mode codes
  localparam logic [5:0]  PD_FILL      = 6'h3F;
  localparam logic [1:0]  PM_HIZ_A     = 2'h0;
  localparam logic [1:0]  PM_PULL_1K   = 2'h1;
  localparam logic [1:0]  PM_PULL_100K = 2'h2;

  // readback byte slots and bit counting
  localparam logic [1:0]  IDX_PD       = 2'h0;
  localparam logic [1:0]  IDX_HIGH     = 2'h1;
  localparam logic [1:0]  IDX_LOW      = 2'h2;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  BIT_FIRST    = 3'h0;

  // status word layout
  localparam int          STAT_CTRL_LSB  = 0;
  localparam int          STAT_IDX_LSB   = 8;
  localparam int          STAT_STATE_LSB = 10;

  // byte-level states of the slave
  localparam int ST_W = 9;
  typedef enum logic [ST_W-1:0] {
    ST_IDLE   = 9'h001,
    ST_RXADR  = 9'h002,
    ST_ACKW   = 9'h004,
    ST_RXCTL  = 9'h008,
    ST_ACKC   = 9'h010,
    ST_LOAD   = 9'h020,
    ST_TX     = 9'h040,
    ST_MACK   = 9'h080,
    ST_SKIP   = 9'h100
  } qdr_state_t;

endpackage : qdr_pkg

// ### core/qdr_line_if.sv
// qdr_line_if: bus line events from the front end to the byte engine.
// assumes: all signals are on the system clock, pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none
interface qdr_line_if;
  logic scl_rise;   // clock line rose
  logic scl_fall;   // clock line fell
  logic start_seen; // start or repeated start
  logic stop_seen;  // stop
  logic sda_level;  // synchronised data line
  modport fe   (output scl_rise, output scl_fall, output start_seen, output stop_seen, output sda_level);
  modport core (input scl_rise, input scl_fall, input start_seen, input stop_seen, input sda_level);
endinterface : qdr_line_if
`default_nettype wire

// ### core/qdr_line_sync.sv
// qdr_line_sync: two-flop synchronisers and edge / start / stop detection.
// assumes: scl and sda are asynchronous pins, clk is far faster than scl.
`timescale 1ns/1ps
`default_nettype none
module qdr_line_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw pins
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  // events
  qdr_line_if.fe    line
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  // first stage feeds only the second; prev flops give one cycle of history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_pin};
      sda_sync_reg <= {sda_sync_reg[0], sda_pin};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // start and stop need scl steady high across the sda change
  assign line.scl_rise   = scl_sync_reg[1] & ~scl_prev_reg;
  assign line.scl_fall   = ~scl_sync_reg[1] & scl_prev_reg;
  assign line.start_seen = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  assign line.stop_seen  = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
  assign line.sda_level  = sda_sync_reg[1];

endmodule : qdr_line_sync
`default_nettype wire

// ### core/qdr_readback_top.sv
// qdr_readback_top: readback slave of a quad 10-bit converter's two-wire bus,
// with an apb register file holding channel words, pin address and power mode.
// assumes: an external bus master drives scl; sda is open drain, pulled up outside.
//
// Functional notes
// - master sends address with write bit; on match device acknowledges low
// - control byte follows write address and device acknowledges it
// - control byte: ext address, update mode, don't care, channel, power-down flag
// - repeated start, address with read bit; device acknowledges, ready to send
// - returned data comes from channel chosen by latest control byte
// - flag clear: send high byte then low byte
// - flag set: send power-down status, high byte, low byte
// - status byte: power mode bits at 7 and 6, ones below
// - high byte carries data bits 9 down to 2, msb first
// - low byte carries data bits 1 and 0 on top, rest don't care
// - after last byte master sends stop or repeated start to readdress
// - power mode: 00/11 high impedance, 01 1k to ground, 10 100k
// - channel data registers reset to zero until written
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module qdr_readback_top
#(
  parameter int APB_AW = 8
)
(
  // clock and reset
  input  wire logic                         MCLK,
  input  wire logic                         RST,
  // apb slave
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [APB_AW-1:0]            PADDR,
  input  wire logic [qdr_pkg::APB_DW-1:0]   PWDATA,
  output logic      [qdr_pkg::APB_DW-1:0]   PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  // two-wire bus pins
  input  wire logic                         SCL,
  input  wire logic                         SDA_IN,
  output logic                              SDA_OUT,
  output logic                              SDA_OE_N,
  // output stage state
  output logic                              OUT_HIZ,
  output logic                              OUT_PULL_1K,
  output logic                              OUT_PULL_100K
);
  import qdr_pkg::*;

  // the map decodes eight address bits; narrower buses cannot reach it
  if (APB_AW < APB_AW_MIN)
  begin : g_bad_aw
    $error("qdr_readback_top: APB_AW must be at least 8");
  end

  // picks the byte for a readback slot
  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic [1:0] pm,
                                         input logic [DATA_W-1:0] d);
    logic [7:0] b;
    b = {d[1:0], 6'h00};
    if (idx == IDX_PD)
      b = {pm, PD_FILL};
    else if (idx == IDX_HIGH)
      b = d[9:2];
    return b;
  endfunction : tx_byte

  // zero-extends a small field to a bus word
  function automatic logic [APB_DW-1:0] zx(input logic [DATA_W-1:0] v);
    return {{(APB_DW-DATA_W){1'b0}}, v};
  endfunction : zx

  qdr_line_if line ();

  qdr_line_sync u_sync
  (
    .clk     (MCLK),
    .rst     (RST),
    .scl_pin (SCL),
    .sda_pin (SDA_IN),
    .line    (line.fe)
  );

  // registers
  qdr_state_t             state_reg,    state_next;
  logic [2:0]             bitcnt_reg,   bitcnt_next;
  logic                   full_reg,     full_next;
  logic [7:0]             shift_reg,    shift_next;
  logic [7:0]             tx_reg,       tx_next;
  logic [1:0]             idx_reg,      idx_next;
  logic [7:0]             ctrl_reg,     ctrl_next;
  logic                   oe_n_reg,     oe_n_next;
  logic [DATA_W-1:0]      ch_reg [NUM_CH];
  logic [1:0]             pin_addr_reg;
  logic [1:0]             pmode_reg;
  logic [APB_DW-1:0]      prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  logic                   hiz_reg;
  logic                   pull1k_reg;
  logic                   pull100k_reg;

  // control byte fields and selected channel word
  wire  [1:0]             ctl_chan    = ctrl_reg[CTL_CH_LSB +: 2];
  wire                    ctl_pd      = ctrl_reg[CTL_PD_BIT];
  wire  [1:0]             ctl_ext     = ctrl_reg[CTL_EXT_LSB +: 2];
  wire  [1:0]             ctl_upd     = ctrl_reg[CTL_UPD_LSB +: 2];
  wire  [DATA_W-1:0]      sel_word    = ch_reg[ctl_chan];

  // address byte checks; rw sits in bit 0
  wire                    adr_match   = shift_reg[7:1] == {SLAVE_BASE, pin_addr_reg};
  wire                    adr_read    = shift_reg[0];
  wire  [7:0]             load_byte   = tx_byte(idx_reg, pmode_reg, sel_word);
  wire                    last_slot   = idx_reg == IDX_LOW;
  wire  [1:0]             first_idx   = ctl_pd ? IDX_PD : IDX_HIGH;

  // byte engine: receive on rising scl, drive sda only after falling scl
  always_comb
  begin
    state_next  = state_reg;
    bitcnt_next = bitcnt_reg;
    full_next   = full_reg;
    shift_next  = shift_reg;
    tx_next     = tx_reg;
    idx_next    = idx_reg;
    ctrl_next   = ctrl_reg;
    oe_n_next   = oe_n_reg;
    if (line.stop_seen)
    begin
      state_next = ST_IDLE;
      oe_n_next  = 1'b1;
    end
    else if (line.start_seen)
    begin
      // a repeated start always readdresses from the address stage, ST_RXADR
      state_next  = ST_RXADR;
      bitcnt_next = BIT_FIRST;
      full_next   = 1'b0;
      oe_n_next   = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE, ST_SKIP:
        begin
          oe_n_next = 1'b1;
        end
        ST_RXADR, ST_RXCTL:
        begin
          if (line.scl_rise)
          begin
            shift_next  = {shift_reg[6:0], line.sda_level};
            bitcnt_next = bitcnt_reg + 3'h1;
            full_next   = bitcnt_reg == BIT_LAST;
          end
          else if (line.scl_fall && full_reg)
          begin
            full_next = 1'b0;
            if (state_reg == ST_RXCTL)
            begin
              ctrl_next  = shift_reg;
              oe_n_next  = 1'b0;
              state_next = ST_ACKC;
            end
            else if (!adr_match)
              state_next = ST_SKIP;
            else if (adr_read)
            begin
              oe_n_next  = 1'b0;
              idx_next   = first_idx;
              state_next = ST_LOAD;
            end
            else
            begin
              oe_n_next  = 1'b0;
              state_next = ST_ACKW;
            end
          end
        end
        ST_ACKW:
        begin
          if (line.scl_fall)
          begin
            oe_n_next   = 1'b1;
            bitcnt_next = BIT_FIRST;
            state_next  = ST_RXCTL;
          end
        end
        ST_ACKC:
        begin
          // further write bytes are not this block's business; wait for a start
          if (line.scl_fall)
          begin
            oe_n_next  = 1'b1;
            state_next = ST_SKIP;
          end
        end
        ST_LOAD:
        begin
          if (line.scl_fall)
          begin
            oe_n_next   = load_byte[7];
            tx_next     = {load_byte[6:0], 1'b0};
            bitcnt_next = BIT_FIRST;
            state_next  = ST_TX;
          end
        end
        ST_TX:
        begin
          if (line.scl_fall)
          begin
            if (bitcnt_reg == BIT_LAST)
            begin
              oe_n_next  = 1'b1;
              state_next = ST_MACK;
            end
            else
            begin
              oe_n_next   = tx_reg[7];
              tx_next     = {tx_reg[6:0], 1'b0};
              bitcnt_next = bitcnt_reg + 3'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (line.scl_rise)
          begin
            if (line.sda_level)
              state_next = ST_IDLE;
            else if (last_slot)
              state_next = ST_SKIP;
            else
            begin
              idx_next   = idx_reg + 2'h1;
              state_next = ST_LOAD;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_reg  <= ST_IDLE;
      bitcnt_reg <= BIT_FIRST;
      full_reg   <= 1'b0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      idx_reg    <= IDX_PD;
      ctrl_reg   <= CTRL_RST;
      oe_n_reg   <= 1'b1;
    end
    else
    begin
      state_reg  <= state_next;
      bitcnt_reg <= bitcnt_next;
      full_reg   <= full_next;
      shift_reg  <= shift_next;
      tx_reg     <= tx_next;
      idx_reg    <= idx_next;
      ctrl_reg   <= ctrl_next;
      oe_n_reg   <= oe_n_next;
    end
  end

  // apb decode: zero wait states, answer registered in the setup cycle
  wire                    upper_zero = (PADDR >> 8) == '0;
  wire  [7:0]             a8         = PADDR[7:0];
  wire                    hit_pin    = upper_zero && a8 == OFS_PIN_ADDR;
  wire                    hit_pwr    = upper_zero && a8 == OFS_PWR_MODE;
  wire                    hit_stat   = upper_zero && a8 == OFS_STATUS;
  wire                    hit_ch     = upper_zero && a8[7:4] == OFS_CH_BASE[7:4] && a8[1:0] == 2'h0;
  wire  [1:0]             ch_idx     = a8[3:2];
  wire                    hit_any    = hit_pin | hit_pwr | hit_stat | hit_ch;
  wire                    setup_ph   = PSEL & ~PENABLE;
  wire                    wr_go      = PSEL & PENABLE & PWRITE & pready_reg & hit_any;
  wire  [APB_DW-1:0]      stat_word  = zx(DATA_W'(0)) |
                                       (APB_DW'(state_reg) << STAT_STATE_LSB) |
                                       (APB_DW'(idx_reg) << STAT_IDX_LSB) |
                                       (APB_DW'(ctrl_reg) << STAT_CTRL_LSB);
  wire  [APB_DW-1:0]      rd_word    = hit_pin  ? zx(DATA_W'(pin_addr_reg)) :
                                       hit_pwr  ? zx(DATA_W'(pmode_reg)) :
                                       hit_stat ? stat_word :
                                       hit_ch   ? zx(ch_reg[ch_idx]) : '0;

  // power mode to output stage; both 00 and 11 mean open circuit
  wire                    pm_1k      = pmode_reg == PM_PULL_1K;
  wire                    pm_100k    = pmode_reg == PM_PULL_100K;

  // bus answer flops
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~hit_any;
      prdata_reg  <= setup_ph ? rd_word : '0;
    end
  end

  // software registers; the status word is read only
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pin_addr_reg <= PIN_ADDR_RST;
      pmode_reg    <= PWR_MODE_RST;
      for (int i = 0; i < NUM_CH; i++)
        ch_reg[i] <= CH_RST;
    end
    else if (wr_go)
    begin
      if (hit_pin)
        pin_addr_reg <= PWDATA[1:0];
      if (hit_pwr)
        pmode_reg <= PWDATA[1:0];
      if (hit_ch)
        ch_reg[ch_idx] <= PWDATA[DATA_W-1:0];
    end
  end

  // pin and output stage flops
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      hiz_reg      <= 1'b1;
      pull1k_reg   <= 1'b0;
      pull100k_reg <= 1'b0;
    end
    else
    begin
      hiz_reg      <= ~pm_1k & ~pm_100k;
      pull1k_reg   <= pm_1k;
      pull100k_reg <= pm_100k;
    end
  end

  // open drain: data out is a constant low flop, only the enable moves
  logic sda_low_reg;
  always_ff @(posedge MCLK)
  begin
    if (RST)
      sda_low_reg <= 1'b0;
    else
      sda_low_reg <= 1'b0;
  end

  assign SDA_OUT       = sda_low_reg;
  assign SDA_OE_N      = oe_n_reg;
  assign PRDATA        = prdata_reg;
  assign PREADY        = pready_reg;
  assign PSLVERR       = pslverr_reg;
  assign OUT_HIZ       = hiz_reg;
  assign OUT_PULL_1K   = pull1k_reg;
  assign OUT_PULL_100K = pull100k_reg;

  // extended address and update mode bits are captured but steer nothing here
  wire unused_ok = ^{ctl_ext, ctl_upd};

endmodule : qdr_readback_top
`default_nettype wire

// ### tb/qdr_readback_assertions.sv
// qdr_readback_assertions: port-level checks of the readback slave, bound to its top.
// assumes: the apb master holds each request until pready, and the bus master moves sda with scl high only for start and stop.
`timescale 1ns/1ps
`default_nettype none
module qdr_readback_assertions
  import qdr_pkg::*;
#(
  parameter int APB_AW = 8
)
(
  // clock and reset
  input wire logic                MCLK,
  input wire logic                RST,
  // apb slave
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PWRITE,
  input wire logic [APB_AW-1:0]   PADDR,
  input wire logic [APB_DW-1:0]   PWDATA,
  input wire logic [APB_DW-1:0]   PRDATA,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  // two-wire pins
  input wire logic                SCL,
  input wire logic                SDA_IN,
  input wire logic                SDA_OUT,
  input wire logic                SDA_OE_N,
  // output stage
  input wire logic                OUT_HIZ,
  input wire logic                OUT_PULL_1K,
  input wire logic                OUT_PULL_100K
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // access edge of a write to the power mode register
  wire logic pm_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == APB_AW'(OFS_PWR_MODE));

  // open drain: the device may only ever pull low
  chk_sda_only_low: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  chk_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  chk_ready_has_cause: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE))
    else $error("ready without setup");
  chk_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error outside access");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  // exactly one output stage state at a time
  chk_stage_onehot: assert property ($onehot({OUT_HIZ, OUT_PULL_1K, OUT_PULL_100K}))
    else $error("output stage not one-hot");
  chk_pull_1k_mode: assert property (pm_wr && PWDATA[1:0] == 2'h1 |-> ##[1:2] (OUT_PULL_1K && !OUT_HIZ))
    else $error("mode 01 not 1k pull");
  chk_pull_100k_mode: assert property (pm_wr && PWDATA[1:0] == 2'h2 |-> ##[1:2] OUT_PULL_100K)
    else $error("mode 10 not 100k pull");
  chk_hiz_mode: assert property (pm_wr && PWDATA[0] == PWDATA[1] |-> ##[1:2] OUT_HIZ)
    else $error("mode 00 or 11 not high impedance");
  // a bit must not move while the clock is high, or the master sees a start or stop
  chk_sda_moves_low: assert property ($changed(SDA_OE_N) |-> !SCL && !$past(SCL, 2))
    else $error("data moved near clock high");
endmodule : qdr_readback_assertions

bind qdr_readback_top qdr_readback_assertions #(.APB_AW(APB_AW)) u_chk
(
  .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .OUT_HIZ(OUT_HIZ), .OUT_PULL_1K(OUT_PULL_1K), .OUT_PULL_100K(OUT_PULL_100K)
);
`default_nettype wire

// ### tb/qdr_bus_master.sv
// qdr_bus_master: behavioural two-wire bus master, driven through its tasks.
// assumes: sda is the resolved open-drain line; 10 clocks of clk make half an scl period.
`timescale 1ns/1ps
`default_nettype none
module qdr_bus_master
(
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_oe_n
);
  // idle bus: both lines released
  initial
  begin
    scl      = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // start or repeated start; waits first so sda never moves at an scl edge
  task automatic start_cond();
    wt(5);
    sda_oe_n <= 1'b1;
    wt(5);
    scl      <= 1'b1;
    wt(5);
    sda_oe_n <= 1'b0;
    wt(5);
    scl      <= 1'b0;
  endtask : start_cond
  // stop leaves scl high, standing still until the next frame
  task automatic stop_cond();
    wt(5);
    sda_oe_n <= 1'b0;
    wt(5);
    scl      <= 1'b1;
    wt(10);
    sda_oe_n <= 1'b1;
    wt(20);
  endtask : stop_cond
  // one clock pulse; the line is sampled mid-high, off the sampling edge
  task automatic bit_xfer(input logic b, output logic r);
    wt(5);
    sda_oe_n <= b;
    wt(5);
    scl      <= 1'b1;
    wt(5);
    @(negedge clk);
    r = sda;
    wt(5);
    scl      <= 1'b0;
  endtask : bit_xfer
  // send msb first; ack comes back low when the slave accepts
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, ack);
  endtask : wr_byte
  // take a byte msb first, then acknowledge, or not on the last one
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask : rd_byte
endmodule : qdr_bus_master
`default_nettype wire

// ### tb/testbench.sv
// testbench: apb set-up plus readback frames through the bus master model.
// assumes: qdr_pkg compiled first; the checker is bound to the top.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) \
    begin \
      miscompares++; \
      $display("unexpected %s: expected %0h, seen %0h", nm, ex, gt); \
    end \
  end
module testbench;
  import qdr_pkg::*;
  logic        MCLK, RST, PSEL, PENABLE, PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        PREADY, PSLVERR, SCL, SDA_OUT, SDA_OE_N, OUT_HIZ, OUT_PULL_1K, OUT_PULL_100K;
  logic        m_oe_n;
  logic [1:0]  pin;
  logic [9:0]  dat [4] = '{10'h2A5, 10'h15A, 10'h3FF, 10'h001};
  int          miscompares, num_checks;
  // open drain with pull-up: low if either party pulls
  wire logic   sda_w = (SDA_OE_N ? 1'b1 : SDA_OUT) & m_oe_n;

  qdr_readback_top #(.APB_AW(8)) uut
  (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SCL(SCL), .SDA_IN(sda_w), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .OUT_HIZ(OUT_HIZ), .OUT_PULL_1K(OUT_PULL_1K), .OUT_PULL_100K(OUT_PULL_100K)
  );
  qdr_bus_master m (.clk(MCLK), .sda(sda_w), .scl(SCL), .sda_oe_n(m_oe_n));

  // 250 MHz system clock
  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // one apb transfer; an edge passes after release so calls never collide
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1)
    begin
      miscompares++;
      print_verdict();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : apb

  // full readback frame; sr_open means a repeated start is already on the bus
  task automatic readback(input logic [7:0] ctl, input logic [9:0] d, input logic [1:0] pm,
                          input logic sr_open, input logic end_sr);
    logic        ack;
    logic [7:0]  b;
    logic [31:0] rd;
    logic        err;
    if (!sr_open)
      m.start_cond();
    m.wr_byte({SLAVE_BASE, pin, 1'b0}, ack);
    `CHK("write address ack", 1'b0, ack);
    m.wr_byte(ctl, ack);
    `CHK("control ack", 1'b0, ack);
    m.start_cond();
    m.wr_byte({SLAVE_BASE, pin, 1'b1}, ack);
    `CHK("read address ack", 1'b0, ack);
    if (ctl[0])
    begin
      m.rd_byte(1'b0, b);
      `CHK("status byte", {pm, 6'h3F}, b);
    end
    m.rd_byte(1'b0, b);
    `CHK("high byte", d[9:2], b);
    m.rd_byte(1'b1, b);
    `CHK("low byte", d[1:0], b[7:6]);
    `CHK("line released", 1'b1, SDA_OE_N);
    // the no-acknowledge must also drop the engine back to ST_IDLE
    apb(1'b0, OFS_STATUS, 32'h0, rd, err);
    `CHK("idle after nack", ST_IDLE, rd[STAT_STATE_LSB +: ST_W]);
    if (end_sr)
      m.start_cond();
    else
      m.stop_cond();
  endtask : readback

  initial
  begin
    logic [31:0] rd;
    logic        err, ack;
    logic [1:0]  pm;
    logic [7:0]  ctl;
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    pin = 2'h0;
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    repeat (5) @(posedge MCLK);
    // reset state: zero channels, unmapped refusal, channel 0 read with control byte 00
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b0, OFS_CH_BASE + 8'(4 * c), 32'h0, rd, err);
      `CHK("channel reset", 32'h0, rd);
    end
    apb(1'b0, 8'h0C, 32'h0, rd, err);
    `CHK("unmapped error", 1'b1, err);
    readback(8'h00, 10'h000, 2'h0, 1'b0, 1'b0);
    $display("test reset done");
    // load channels and pin address, then a foreign address must go unanswered
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, OFS_CH_BASE + 8'(4 * c), {22'h0, dat[c]}, rd, err);
      apb(1'b0, OFS_CH_BASE + 8'(4 * c), 32'h0, rd, err);
      `CHK("channel word", {22'h0, dat[c]}, rd);
    end
    apb(1'b1, OFS_PIN_ADDR, 32'h2, rd, err);
    pin = 2'h2;
    m.start_cond();
    m.wr_byte({SLAVE_BASE, 2'h1, 1'b0}, ack);
    `CHK("foreign address ack", 1'b1, ack);
    m.stop_cond();
    $display("test addressing done");
    // every channel with flag clear then set, every power mode, stop and repeated start
    for (int i = 0; i < 8; i++)
    begin
      pm = 2'(i + 1);
      ctl = {2'h2, 2'h1, 1'b0, 2'(i), i[2]};
      apb(1'b1, OFS_PWR_MODE, {30'h0, pm}, rd, err);
      repeat (3) @(posedge MCLK);
      `CHK("stage", pm == 2'h1 ? 3'h2 : pm == 2'h2 ? 3'h1 : 3'h4, {OUT_HIZ, OUT_PULL_1K, OUT_PULL_100K});
      readback(ctl, dat[i % 4], pm, i[0], ~i[0]);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      `CHK("stored control", ctl, rd[7:0]);
    end
    $display("test readback done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
